// ### rtl/clk_gate_pkg.sv
// Overview of operation
// - Each gating bit is the clock enable of one unit; 0 stops and disables it.
// - Access to a unit whose clock is gated off returns a bus fault.
// - All gating bits and the ADC rate field reset to zero.
// - Three register copies: run, sleep, deep sleep; current mode's copy applies.
// - Sleep and deep-sleep copies apply only while auto gating is set.
// - Set 0 at 0x100/0x110/0x120, set 1 at 0x104/0x114/0x124.
// - Set 0: bit 20 PWM, bit 16 ADC, bit 3 watchdog, bits 11:8 rate; rest reserved.
// - Set 0 bits 11:8 pick ADC rate: 0 125K, 1 250K, 2 500K, 3 1M.
// - Set 1: bit 24 comparator 0, bits 18/17/16 timers 2/1/0.
// - Set 1: bit 8 encoder, bit 4 sync serial, bits 1/0 serial ports.
// - Reserved bits are undefined on read; software preserves them.
package clk_gate_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] OFS_RUN0 = 12'h100;
    localparam logic [11:0] OFS_RUN1 = 12'h104;
    localparam logic [11:0] OFS_SLP0 = 12'h110;
    localparam logic [11:0] OFS_SLP1 = 12'h114;
    localparam logic [11:0] OFS_DSL0 = 12'h120;
    localparam logic [11:0] OFS_DSL1 = 12'h124;
    localparam logic [11:0] OFS_RUN_CLOCK_CONFIG = 12'h060;
    localparam logic [11:0] OFS_FAULT_STATUS = 12'h180;
    localparam logic [11:0] OFS_FAULT_MASK = 12'h184;
    localparam logic [11:0] OFS_MODE_STATUS = 12'h188;
    // ****************************************
    // Fields
    // ****************************************
    localparam int BIT_PWM = 20;
    localparam int BIT_ADC = 16;
    localparam int BIT_WATCHDOG = 3;
    localparam int RATE_LO = 8;
    localparam int RATE_HI = 11;
    localparam int BIT_COMPARATOR0_GATE_BIT = 24;
    localparam int BIT_TIMER2 = 18;
    localparam int BIT_TIMER1 = 17;
    localparam int BIT_TIMER0 = 16;
    localparam int BIT_ENCODER = 8;
    localparam int BIT_SYNC_SERIAL = 4;
    localparam int BIT_SERIAL1 = 1;
    localparam int BIT_SERIAL0 = 0;
    localparam int BIT_AUTO_GATING = 27;
    localparam logic [31:0] MASK_SET0 = 32'h0011_0F08;
    localparam logic [31:0] MASK_SET1 = 32'h0107_0113;
    localparam logic [31:0] MASK_RCC = 32'h0800_0000;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    localparam logic [3:0] RATE_MAX_CODE = 4'h3;
    localparam int NUM_UNITS = 11;
    localparam int NUM_FAULT = 2;
    localparam int BIT_FAULT_ACCESS = 0;
    localparam int BIT_FAULT_RATE = 1;

    typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP_SLEEP} power_mode_e;

    typedef struct packed {
        logic pwm;
        logic adc;
        logic watchdog;
        logic comparator0_gate_bit;
        logic timer2;
        logic timer1;
        logic timer0;
        logic encoder;
        logic sync_serial;
        logic serial1;
        logic serial0;
    } unit_enables_s;
endpackage : clk_gate_pkg

// ### rtl/gate_reg_bank.sv
`timescale 1ns/100ps
// Six gating words in a small register bank; read data come out of a register.
module gate_reg_bank (
    input wire logic clk, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic wr_en, // Write strobe
    input wire logic [2:0] wr_idx, // Word written
    input wire logic [31:0] wr_data, // Write data, already masked
    input wire logic [2:0] rd_idx, // Word read
    output logic [31:0] rd_data, // Registered read data
    output logic [5:0][31:0] words // All words, for the gating decode
);
    logic [5:0][31:0] next_words;
    logic [31:0] next_rd_data;

    always_comb begin
        next_words = words;
        if (wr_en && wr_idx < 3'd6) begin
            next_words[wr_idx] = wr_data;
        end
        next_rd_data = (rd_idx < 3'd6) ? words[rd_idx] : clk_gate_pkg::RESET_VALUE;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            words <= {6{clk_gate_pkg::RESET_VALUE}};
            rd_data <= '0;
        end else begin
            words <= next_words;
            rd_data <= next_rd_data;
        end
    end
endmodule : gate_reg_bank

// ### rtl/peripheral_clock_gating.sv
`timescale 1ns/100ps
module peripheral_clock_gating (
    input wire logic clk, // System clock, 25 MHz
    input wire logic reset_n, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic sleep_req, // Core is in sleep
    input wire logic deep_sleep_req, // Core is in deep sleep
    input wire logic unit_access, // Peripheral access in progress
    input wire logic [3:0] unit_sel, // Unit being accessed, struct field order, pwm = 0 to serial0 = 10
    output logic unit_fault, // Bus fault pulse for a gated unit
    output clk_gate_pkg::unit_enables_s unit_clk_en, // Clock enable per unit
    output logic [3:0] adc_rate, // ADC sample rate code
    output logic irq // Level interrupt
);
    // ****************************************
    // Decode
    // ****************************************
    function automatic logic [2:0] word_index(input logic [11:0] a);
        case (a)
            clk_gate_pkg::OFS_RUN0: word_index = 3'd0;
            clk_gate_pkg::OFS_RUN1: word_index = 3'd1;
            clk_gate_pkg::OFS_SLP0: word_index = 3'd2;
            clk_gate_pkg::OFS_SLP1: word_index = 3'd3;
            clk_gate_pkg::OFS_DSL0: word_index = 3'd4;
            clk_gate_pkg::OFS_DSL1: word_index = 3'd5;
            default: word_index = 3'd7;
        endcase
    endfunction : word_index

    function automatic clk_gate_pkg::unit_enables_s decode_units(
        input logic [31:0] w0,
        input logic [31:0] w1
    );
        decode_units.pwm = w0[clk_gate_pkg::BIT_PWM];
        decode_units.adc = w0[clk_gate_pkg::BIT_ADC];
        decode_units.watchdog = w0[clk_gate_pkg::BIT_WATCHDOG];
        decode_units.comparator0_gate_bit = w1[clk_gate_pkg::BIT_COMPARATOR0_GATE_BIT];
        decode_units.timer2 = w1[clk_gate_pkg::BIT_TIMER2];
        decode_units.timer1 = w1[clk_gate_pkg::BIT_TIMER1];
        decode_units.timer0 = w1[clk_gate_pkg::BIT_TIMER0];
        decode_units.encoder = w1[clk_gate_pkg::BIT_ENCODER];
        decode_units.sync_serial = w1[clk_gate_pkg::BIT_SYNC_SERIAL];
        decode_units.serial1 = w1[clk_gate_pkg::BIT_SERIAL1];
        decode_units.serial0 = w1[clk_gate_pkg::BIT_SERIAL0];
    endfunction : decode_units

    logic setup;
    logic access;
    logic [2:0] idx;
    logic bank_wr;
    logic [31:0] bank_wdata;
    logic [31:0] bank_rdata;
    logic [5:0][31:0] words;
    logic [31:0] run_clock_config;
    logic [31:0] next_run_clock_config;
    logic [clk_gate_pkg::NUM_FAULT-1:0] fault_status;
    logic [clk_gate_pkg::NUM_FAULT-1:0] next_fault_status;
    logic [clk_gate_pkg::NUM_FAULT-1:0] fault_mask;
    logic [clk_gate_pkg::NUM_FAULT-1:0] next_fault_mask;
    logic bank_sel;
    logic next_bank_sel;
    logic [31:0] local_rdata;
    logic [31:0] next_local_rdata;
    logic next_pready;
    logic next_pslverr;
    logic unmapped;
    logic next_unmapped;
    logic [31:0] next_prdata;
    logic auto_gating_select;
    clk_gate_pkg::power_mode_e mode;
    clk_gate_pkg::unit_enables_s next_unit_clk_en;
    logic [3:0] next_adc_rate;
    logic next_unit_fault;
    logic next_irq;
    logic [31:0] sel0;
    logic [31:0] sel1;

    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    assign idx = word_index(paddr);
    assign auto_gating_select = run_clock_config[clk_gate_pkg::BIT_AUTO_GATING];

    // ****************************************
    // Register bank
    // ****************************************
    always_comb begin
        bank_wr = access && pwrite && idx != 3'd7;
        // Unimplemented bits held at zero so reserved reads are stable
        bank_wdata = pwdata & (idx[0] ? clk_gate_pkg::MASK_SET1 : clk_gate_pkg::MASK_SET0);
    end

    gate_reg_bank gate_reg_bank_i (
        .clk(clk),
        .reset_n(reset_n),
        .wr_en(bank_wr),
        .wr_idx(idx),
        .wr_data(bank_wdata),
        .rd_idx(idx),
        .rd_data(bank_rdata),
        .words(words)
    );

    // ****************************************
    // APB slave: one wait state, answer registered
    // ****************************************
    always_comb begin
        next_pready = psel && penable && !pready;
        next_unmapped = unmapped;
        next_bank_sel = bank_sel;
        next_local_rdata = local_rdata;
        next_run_clock_config = run_clock_config;
        next_fault_mask = fault_mask;
        if (setup) begin
            next_bank_sel = idx != 3'd7;
            next_unmapped = 1'b0;
            case (paddr)
                clk_gate_pkg::OFS_RUN_CLOCK_CONFIG: next_local_rdata = run_clock_config;
                clk_gate_pkg::OFS_FAULT_STATUS: next_local_rdata = 32'(fault_status);
                clk_gate_pkg::OFS_FAULT_MASK: next_local_rdata = 32'(fault_mask);
                clk_gate_pkg::OFS_MODE_STATUS: next_local_rdata = 32'(mode);
                default: begin
                    next_local_rdata = 32'h0000_0000;
                    next_unmapped = idx == 3'd7;
                end
            endcase
        end
        if (access && pwrite) begin
            case (paddr)
                clk_gate_pkg::OFS_RUN_CLOCK_CONFIG:
                    next_run_clock_config = pwdata & clk_gate_pkg::MASK_RCC;
                clk_gate_pkg::OFS_FAULT_MASK:
                    next_fault_mask = pwdata[clk_gate_pkg::NUM_FAULT-1:0];
                default: next_fault_mask = fault_mask;
            endcase
        end
        // Bank word lands a cycle after setup, so the answer waits one cycle
        next_pslverr = next_pready && unmapped;
        next_prdata = next_pready ? (bank_sel ? bank_rdata : local_rdata) : prdata;
    end

    // ****************************************
    // Gating selection
    // ****************************************
    always_comb begin
        sel0 = words[0];
        sel1 = words[1];
        if (auto_gating_select) begin
            case (mode)
                clk_gate_pkg::MODE_SLEEP: begin
                    sel0 = words[2];
                    sel1 = words[3];
                end
                clk_gate_pkg::MODE_DEEP_SLEEP: begin
                    sel0 = words[4];
                    sel1 = words[5];
                end
                default: begin
                    sel0 = words[0];
                    sel1 = words[1];
                end
            endcase
        end
        next_unit_clk_en = decode_units(sel0, sel1);
        next_adc_rate = sel0[clk_gate_pkg::RATE_HI:clk_gate_pkg::RATE_LO];
        // Gated unit cannot answer; fault instead
        next_unit_fault = unit_access && unit_sel < 4'(clk_gate_pkg::NUM_UNITS)
            && !unit_clk_en[4'(clk_gate_pkg::NUM_UNITS - 1) - unit_sel];
    end

    always_comb begin
        mode = deep_sleep_req ? clk_gate_pkg::MODE_DEEP_SLEEP :
            sleep_req ? clk_gate_pkg::MODE_SLEEP : clk_gate_pkg::MODE_RUN;
    end

    // ****************************************
    // Interrupt status
    // ****************************************
    always_comb begin
        next_fault_status = fault_status;
        if (access && pwrite && paddr == clk_gate_pkg::OFS_FAULT_STATUS) begin
            next_fault_status = fault_status & ~pwdata[clk_gate_pkg::NUM_FAULT-1:0];
        end
        // Set wins over a same-cycle clear
        if (next_unit_fault) begin
            next_fault_status[clk_gate_pkg::BIT_FAULT_ACCESS] = 1'b1;
        end
        // Flags a rate code beyond the top supported rate
        if (next_adc_rate > clk_gate_pkg::RATE_MAX_CODE) begin
            next_fault_status[clk_gate_pkg::BIT_FAULT_RATE] = 1'b1;
        end
        next_irq = |(next_fault_status & next_fault_mask);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
            unmapped <= 1'b0;
            bank_sel <= 1'b0;
            local_rdata <= '0;
            run_clock_config <= '0;
            fault_status <= '0;
            fault_mask <= '0;
            unit_clk_en <= '0;
            adc_rate <= '0;
            unit_fault <= 1'b0;
            irq <= 1'b0;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
            unmapped <= next_unmapped;
            bank_sel <= next_bank_sel;
            local_rdata <= next_local_rdata;
            run_clock_config <= next_run_clock_config;
            fault_status <= next_fault_status;
            fault_mask <= next_fault_mask;
            unit_clk_en <= next_unit_clk_en;
            adc_rate <= next_adc_rate;
            unit_fault <= next_unit_fault;
            irq <= next_irq;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    AST_FAULT_WHEN_GATED: assert property (@(posedge clk) disable iff (!reset_n)
        unit_access && unit_sel == 4'd10 && !unit_clk_en.serial0 |=> unit_fault)
        else $error("No fault on gated unit access");
    AST_NO_FAULT_WHEN_CLOCKED: assert property (@(posedge clk) disable iff (!reset_n)
        unit_access && unit_sel == 4'd0 && unit_clk_en.pwm |=> !unit_fault)
        else $error("Fault on clocked unit");
    AST_RUN_COPY_NO_AUTO: assert property (@(posedge clk) disable iff (!reset_n)
        !auto_gating_select |=> unit_clk_en.serial0 == $past(words[1][0]))
        else $error("Run copy not applied");
    AST_SLEEP_COPY: assert property (@(posedge clk) disable iff (!reset_n)
        auto_gating_select && mode == clk_gate_pkg::MODE_SLEEP
        |=> unit_clk_en.timer0 == $past(words[3][clk_gate_pkg::BIT_TIMER0]))
        else $error("Sleep copy not applied");
    AST_DEEP_COPY: assert property (@(posedge clk) disable iff (!reset_n)
        auto_gating_select && mode == clk_gate_pkg::MODE_DEEP_SLEEP
        |=> unit_clk_en.pwm == $past(words[4][clk_gate_pkg::BIT_PWM]))
        else $error("Deep-sleep copy not applied");
    AST_RATE_FIELD: assert property (@(posedge clk) disable iff (!reset_n)
        !auto_gating_select
        |=> adc_rate == $past(words[0][clk_gate_pkg::RATE_HI:clk_gate_pkg::RATE_LO]))
        else $error("Rate field mismatch");
    AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
        (words[1] & ~clk_gate_pkg::MASK_SET1) == 32'h0000_0000)
        else $error("Reserved bit stored");
    AST_WRITE_LANDS: assert property (@(posedge clk) disable iff (!reset_n)
        access && pwrite && paddr == clk_gate_pkg::OFS_RUN0
        |=> words[0] == (($past(pwdata)) & clk_gate_pkg::MASK_SET0))
        else $error("Run word 0 write lost");
    AST_READY_ONE_WAIT: assert property (@(posedge clk) disable iff (!reset_n)
        setup |=> !pready ##1 pready ##1 !pready)
        else $error("Ready timing wrong");
    AST_READY_PULSE: assert property (@(posedge clk) disable iff (!reset_n)
        pready |=> !pready)
        else $error("Ready held too long");
    AST_ERR_WITH_READY: assert property (@(posedge clk) disable iff (!reset_n)
        pslverr |-> pready)
        else $error("Error without ready");
    AST_ERR_READS_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
        pslverr |-> prdata == 32'h0000_0000)
        else $error("Error read not zero");
    AST_DSL1_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
        access && pwrite && paddr == clk_gate_pkg::OFS_DSL1
        |=> words[5] == ($past(pwdata) & clk_gate_pkg::MASK_SET1))
        else $error("Deep-sleep word 1 write lost");
    AST_RESERVED_ZERO_SET0: assert property (@(posedge clk) disable iff (!reset_n)
        (words[0] & ~clk_gate_pkg::MASK_SET0) == 32'h0000_0000)
        else $error("Reserved bit stored in set 0");
    AST_RESERVED_ZERO_DEEP: assert property (@(posedge clk) disable iff (!reset_n)
        (words[5] & ~clk_gate_pkg::MASK_SET1) == 32'h0000_0000)
        else $error("Reserved bit stored in deep word");
    AST_SLEEP_RUN_COPY: assert property (@(posedge clk) disable iff (!reset_n)
        !auto_gating_select && mode == clk_gate_pkg::MODE_SLEEP
        |=> unit_clk_en.pwm == $past(words[0][clk_gate_pkg::BIT_PWM]))
        else $error("Run copy not kept in sleep");
    AST_DEEP_RATE: assert property (@(posedge clk) disable iff (!reset_n)
        auto_gating_select && mode == clk_gate_pkg::MODE_DEEP_SLEEP
        |=> adc_rate == $past(words[4][clk_gate_pkg::RATE_HI:clk_gate_pkg::RATE_LO]))
        else $error("Deep-sleep rate not applied");
    AST_FAULT_STICKY: assert property (@(posedge clk) disable iff (!reset_n)
        unit_fault |-> fault_status[clk_gate_pkg::BIT_FAULT_ACCESS])
        else $error("Fault not recorded");
    AST_FAULT_NEEDS_ACCESS: assert property (@(posedge clk) disable iff (!reset_n)
        unit_fault |-> $past(unit_access))
        else $error("Fault without access");
    AST_NO_FAULT_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
        !unit_access |=> !unit_fault)
        else $error("Fault while idle");
    AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!reset_n)
        irq == |(fault_status & fault_mask))
        else $error("Interrupt level wrong");
endmodule : peripheral_clock_gating

// ### testbench/peripheral_clock_gating_bench.sv
`timescale 1ns/100ps
module peripheral_clock_gating_bench;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] x;
    } row_s;
    localparam logic [11:0] R0 = clk_gate_pkg::OFS_RUN0;
    localparam logic [11:0] R1 = clk_gate_pkg::OFS_RUN1;
    localparam logic [11:0] S0 = clk_gate_pkg::OFS_SLP0;
    localparam logic [11:0] D0 = clk_gate_pkg::OFS_DSL0;
    localparam logic [11:0] CFG = clk_gate_pkg::OFS_RUN_CLOCK_CONFIG;
    localparam logic [11:0] FST = clk_gate_pkg::OFS_FAULT_STATUS;
    localparam logic [11:0] FMK = clk_gate_pkg::OFS_FAULT_MASK;
    localparam logic [11:0] MST = clk_gate_pkg::OFS_MODE_STATUS;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sleep_req = 1'b0;
    logic deep_sleep_req = 1'b0;
    logic unit_access = 1'b0;
    logic [3:0] unit_sel = 4'h0;
    logic unit_fault;
    clk_gate_pkg::unit_enables_s unit_clk_en;
    logic [3:0] adc_rate;
    logic irq;
    int err_count = 0;
    int samples_checked = 0;
    int k;
    logic [31:0] rd;
    logic er;
    // Reserved bits are not stored, so read-back is the field mask
    row_s rows [9] = '{'{R0, ALL, clk_gate_pkg::MASK_SET0}, '{R1, ALL, clk_gate_pkg::MASK_SET1},
        '{S0, ALL, clk_gate_pkg::MASK_SET0}, '{clk_gate_pkg::OFS_SLP1, ALL, clk_gate_pkg::MASK_SET1},
        '{D0, ALL, clk_gate_pkg::MASK_SET0}, '{clk_gate_pkg::OFS_DSL1, ALL, clk_gate_pkg::MASK_SET1},
        '{CFG, ALL, clk_gate_pkg::MASK_RCC}, '{FMK, ALL, 32'h0000_0003}, '{MST, ALL, 32'h0000_0000}};
    logic [11:0] ua [11] = '{R0, R0, R0, R1, R1, R1, R1, R1, R1, R1, R1};
    int ub [11] = '{20, 16, 3, 24, 18, 17, 16, 8, 4, 1, 0};

    always #20 clk = ~clk;

    peripheral_clock_gating peripheral_clock_gating_i (.clk(clk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
        .deep_sleep_req(deep_sleep_req), .unit_access(unit_access), .unit_sel(unit_sel),
        .unit_fault(unit_fault), .unit_clk_en(unit_clk_en), .adc_rate(adc_rate), .irq(irq));

    // ****************************************
    // Helpers
    // ****************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n), 32'h0000_0001);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Enables lag a register or mode change by one edge; settle waits two
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task poke(input logic [3:0] u, input logic f);
        @(posedge clk);
        unit_access <= 1'b1;
        unit_sel <= u;
        @(posedge clk);
        unit_access <= 1'b0;
        #1;
        chk({31'h0, unit_fault}, {31'h0, f});
    endtask : poke

    task test_done;
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    initial begin
        #(40 * 6000);
        err_count++;
        test_done();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        settle();
        chk({21'h0, unit_clk_en}, 32'h0);
        chk({27'h0, adc_rate, irq}, 32'h0);
        for (int i = 0; i < 6; i++) begin
            apb(rows[i].a, 1'b0, 32'h0);
            chk(rd, 32'h0);
        end
        foreach (rows[i]) begin
            apb(rows[i].a, 1'b1, rows[i].d);
            apb(rows[i].a, 1'b0, 32'h0);
            chk(rd, rows[i].x);
        end
        settle();
        chk({21'h0, unit_clk_en}, 32'h0000_07FF);
        chk({28'h0, adc_rate}, 32'h0000_000F);
        chk({31'h0, irq}, 32'h1);
        for (int i = 0; i < 7; i++) apb(rows[i].a, 1'b1, 32'h0);
        apb(FST, 1'b0, 32'h0);
        chk(rd, 32'h0000_0002);
        apb(FST, 1'b1, 32'h0000_0003);
        apb(FST, 1'b0, 32'h0);
        chk(rd, 32'h0);
        foreach (ub[i]) begin
            apb(R0, 1'b1, (ua[i] == R0) ? (32'h1 << ub[i]) : 32'h0);
            apb(R1, 1'b1, (ua[i] == R1) ? (32'h1 << ub[i]) : 32'h0);
            settle();
            chk({21'h0, unit_clk_en}, 32'h1 << (10 - i));
            poke(4'(i), 1'b0);
            poke(4'((i + 1) % 11), 1'b1);
        end
        settle();
        chk({31'h0, irq}, 32'h1);
        apb(FMK, 1'b1, 32'h0);
        settle();
        chk({31'h0, irq}, 32'h0);
        apb(FST, 1'b0, 32'h0);
        chk(rd, 32'h0000_0001);
        apb(FST, 1'b1, 32'h0000_0001);
        apb(FST, 1'b0, 32'h0);
        chk(rd, 32'h0);
        // Distinct unit and rate per copy show which copy is in force
        apb(R0, 1'b1, 32'h0010_0100);
        apb(R1, 1'b1, 32'h0);
        apb(S0, 1'b1, 32'h0001_0200);
        apb(D0, 1'b1, 32'h0000_0308);
        for (int g = 0; g < 2; g++) begin
            apb(CFG, 1'b1, (g == 1) ? clk_gate_pkg::MASK_RCC : 32'h0);
            for (int m = 0; m < 3; m++) begin
                @(posedge clk);
                sleep_req <= (m != 0);
                deep_sleep_req <= (m == 2);
                settle();
                k = (g == 1) ? m : 0;
                chk({21'h0, unit_clk_en}, 32'h400 >> k);
                chk({28'h0, adc_rate}, 32'(k + 1));
                apb(MST, 1'b0, 32'h0);
                chk(rd, 32'(m));
            end
        end
        @(posedge clk);
        sleep_req <= 1'b0;
        deep_sleep_req <= 1'b0;
        apb(12'h200, 1'b0, 32'h0);
        chk({er, rd[30:0]}, 32'h8000_0000);
        apb(12'h108, 1'b1, ALL);
        chk({31'h0, er}, 32'h1);
        apb(R1, 1'b1, ALL);
        settle();
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        #1;
        chk({21'h0, unit_clk_en}, 32'h0);
        @(posedge clk);
        reset_n <= 1'b1;
        apb(R1, 1'b0, 32'h0);
        chk(rd, 32'h0);
        test_done();
    end
endmodule : peripheral_clock_gating_bench
